// [hdl/serial_dma_ctrl_status.sv]
// Purpose: Ping-pong DMA control/status for a serial controller
// Assumes: One clock; FIFO and RAM handshakes synchronous
// Notes:   Index 0 is buffer A, index 1 is buffer B
`timescale 1ns/1ns
`include "serial_dma_cfg.svh"

module serial_dma_ctrl_status
  import serial_dma_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Mode and pin
  input  wire logic        uart_mode_i,
  input  wire logic        spi_slave_i,
  input  wire logic        frame_select_n_i,
  // Buffer addresses from the address registers
  input  wire buf_addr_t   tx_buf_a_i,
  input  wire buf_addr_t   tx_buf_b_i,
  input  wire buf_addr_t   rx_buf_a_i,
  input  wire buf_addr_t   rx_buf_b_i,
  // Transmit FIFO
  input  wire logic        tx_space_i,
  output logic             tx_push_o,
  output logic      [7:0]  tx_data_o,
  // Receive FIFO
  input  wire logic        rx_avail_i,
  input  wire rx_byte_t    rx_byte_i,
  input  wire logic        rx_fifo_full_i,
  output logic             rx_pop_o,
  // RAM ports
  output logic             tx_mem_req_o,
  output mem_req_t         tx_mem_o,
  input  wire logic        tx_mem_ack_i,
  input  wire logic [7:0]  tx_mem_rdata_i,
  output logic             rx_mem_req_o,
  output mem_req_t         rx_mem_o,
  input  wire logic        rx_mem_ack_i,
  // Saved receive count
  output addr_t            saved_receive_count_o
);

  // ==========================================================
  // Helpers
  function automatic logic buf_done(input buf_addr_t b, input addr_t cnt);
    buf_done = ({1'b0, b.beg} + {1'b0, cnt}) > {1'b0, b.fin};
  endfunction

  // Active pointer after loads, unloads and new loads
  function automatic logic next_sel(input logic [1:0] load, input logic [1:0] unload,
                                    input logic [1:0] set,  input logic sel);
    logic [1:0] keep;
    keep = load & ~unload;
    if (keep == 2'b00 && set != 2'b00)
      next_sel = ~set[0];
    else if (unload != 2'b00)
      next_sel = ~sel;
    else
      next_sel = sel;
  endfunction

  // ==========================================================
  // Registers
  logic        wr_pend_r;
  logic [31:0] wr_addr_r;
  logic [31:0] hrdata_r;
  logic        hreadyout_r;
  logic        hresp_r;

  logic [1:0]  tx_load_r;
  logic [1:0]  rx_load_r;
  logic        tx_sel_r;
  logic        rx_sel_r;
  addr_t       tx_cnt_r [2];
  addr_t       rx_cnt_r [2];
  chan_state_t tx_state_r;
  chan_state_t rx_state_r;
  logic        tx_push_r;
  logic [7:0]  tx_data_r;
  logic        rx_pop_r;
  logic        tx_mem_req_r;
  mem_req_t    tx_mem_r;
  logic        rx_mem_req_r;
  mem_req_t    rx_mem_r;
  logic [1:0]  rx_frm_r;
  logic [1:0]  rx_par_r;
  logic [1:0]  rx_ovf_r;
  logic        ovr_pend_r;
  logic        fsn_q_r;
  logic [2:0]  ssel_r;
  addr_t       saved_cnt_r;

  // ==========================================================
  // Decode of a control write in its data phase
  logic        ctl_wr;
  logic        tx_rst_go;
  logic        rx_rst_go;
  logic [1:0]  tx_set;
  logic [1:0]  rx_set;

  assign ctl_wr    = wr_pend_r && (wr_addr_r == `CONTROL_ADDR);
  assign tx_rst_go = ctl_wr && hwdata_i[`CTL_TX_RST];
  assign rx_rst_go = ctl_wr && hwdata_i[`CTL_RX_RST];
  // Writing zero to a load bit is ignored
  assign tx_set    = ctl_wr ? hwdata_i[`CTL_TX_LOAD_MSB:`CTL_TX_LOAD_LSB] : 2'b00;
  assign rx_set    = ctl_wr ? hwdata_i[`CTL_RX_LOAD_MSB:`CTL_RX_LOAD_LSB] : 2'b00;

  // ==========================================================
  // Channel decisions
  buf_addr_t   tx_buf;
  buf_addr_t   rx_buf;
  logic        tx_done;
  logic        rx_done;
  logic [1:0]  tx_unload;
  logic [1:0]  rx_unload;
  logic        tx_start;
  logic        rx_start;
  logic        tx_ack_go;
  logic        rx_ack_go;

  assign tx_buf    = tx_sel_r ? tx_buf_b_i : tx_buf_a_i;
  assign rx_buf    = rx_sel_r ? rx_buf_b_i : rx_buf_a_i;
  assign tx_done   = buf_done(tx_buf, tx_cnt_r[tx_sel_r]);
  assign rx_done   = buf_done(rx_buf, rx_cnt_r[rx_sel_r]);
  // Unload only between transfers so no access is cut short
  assign tx_unload = (tx_state_r == ST_IDLE && tx_load_r[tx_sel_r] && tx_done)
                     ? (tx_sel_r ? 2'b10 : 2'b01) : 2'b00;
  assign rx_unload = (rx_state_r == ST_IDLE && rx_load_r[rx_sel_r] && rx_done)
                     ? (rx_sel_r ? 2'b10 : 2'b01) : 2'b00;
  assign tx_start  = tx_state_r == ST_IDLE && tx_load_r[tx_sel_r] && !tx_done
                     && tx_space_i && !tx_push_r && !tx_rst_go;
  assign rx_start  = rx_state_r == ST_IDLE && rx_load_r[rx_sel_r] && !rx_done
                     && rx_avail_i && !rx_pop_r && !rx_rst_go;
  assign tx_ack_go = tx_state_r == ST_WAIT && tx_mem_ack_i && !tx_rst_go;
  assign rx_ack_go = rx_state_r == ST_WAIT && rx_mem_ack_i && !rx_rst_go;

  // ==========================================================
  // Status word
  logic [31:0] status_word;
  logic [31:0] control_word;

  always_comb begin
    status_word        = 32'h0000_0000;
    status_word[12:10] = ssel_r;
    status_word[9:8]   = rx_frm_r;
    status_word[7:6]   = rx_par_r;
    status_word[5:4]   = rx_ovf_r;
    status_word[3]     = tx_load_r[1] && tx_sel_r;
    status_word[2]     = tx_load_r[0] && !tx_sel_r;
    status_word[1]     = rx_load_r[1] && rx_sel_r;
    status_word[0]     = rx_load_r[0] && !rx_sel_r;
    control_word       = 32'h0000_0000;
    // Reset bits always read zero
    control_word[`CTL_TX_LOAD_MSB:`CTL_TX_LOAD_LSB] = tx_load_r;
    control_word[`CTL_RX_LOAD_MSB:`CTL_RX_LOAD_LSB] = rx_load_r;
  end

  // ==========================================================
  // AHB-Lite slave, zero wait states, always OKAY
  logic ahb_go;
  assign ahb_go = hsel_i && htrans_i[`HTRANS_BUSY_BIT] && hready_i;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_pend_r   <= 1'b0;
      wr_addr_r   <= 32'h0000_0000;
      hrdata_r    <= `HRDATA_RESET;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
      if (hready_i) begin
        wr_pend_r <= ahb_go && hwrite_i;
        wr_addr_r <= haddr_i;
      end
      // Read data captured at the address phase; unmapped reads zero
      if (ahb_go && !hwrite_i) begin
        if (haddr_i == `STATUS_ADDR)
          hrdata_r <= status_word;
        else if (haddr_i == `CONTROL_ADDR)
          hrdata_r <= control_word;
        else
          hrdata_r <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // Load bits and active pointers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_load_r <= 2'b00;
      tx_sel_r  <= 1'b0;
    end else if (tx_rst_go) begin
      tx_load_r <= 2'b00;
      tx_sel_r  <= 1'b0;
    end else begin
      tx_load_r <= (tx_load_r & ~tx_unload) | tx_set;
      tx_sel_r  <= next_sel(tx_load_r, tx_unload, tx_set, tx_sel_r);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_load_r <= 2'b00;
      rx_sel_r  <= 1'b0;
    end else if (rx_rst_go) begin
      rx_load_r <= 2'b00;
      rx_sel_r  <= 1'b0;
    end else begin
      rx_load_r <= (rx_load_r & ~rx_unload) | rx_set;
      rx_sel_r  <= next_sel(rx_load_r, rx_unload, rx_set, rx_sel_r);
    end
  end

  // ==========================================================
  // Byte counts, restarted when their buffer is loaded
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_cnt_r[0] <= '0;
      tx_cnt_r[1] <= '0;
      rx_cnt_r[0] <= '0;
      rx_cnt_r[1] <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (tx_rst_go || tx_set[i])
          tx_cnt_r[i] <= '0;
        else if (tx_ack_go && tx_sel_r == i[0])
          tx_cnt_r[i] <= tx_cnt_r[i] + 14'h0001;
        if (rx_rst_go || rx_set[i])
          rx_cnt_r[i] <= '0;
        else if (rx_ack_go && rx_sel_r == i[0])
          rx_cnt_r[i] <= rx_cnt_r[i] + 14'h0001;
      end
    end
  end

  // ==========================================================
  // Transmit engine: RAM read then FIFO push
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_state_r   <= ST_IDLE;
      tx_mem_req_r <= 1'b0;
      tx_mem_r     <= '0;
      tx_push_r    <= 1'b0;
      tx_data_r    <= 8'h00;
    end else begin
      tx_push_r <= 1'b0;
      unique case (tx_state_r)
        ST_IDLE: begin
          if (tx_start) begin
            tx_state_r     <= ST_WAIT;
            tx_mem_req_r   <= 1'b1;
            tx_mem_r.we    <= 1'b0;
            tx_mem_r.addr  <= tx_buf.beg + tx_cnt_r[tx_sel_r];
            tx_mem_r.wdata <= 8'h00;
          end
        end
        ST_WAIT: begin
          if (tx_rst_go) begin
            tx_state_r   <= ST_IDLE;
            tx_mem_req_r <= 1'b0;
          end else if (tx_mem_ack_i) begin
            tx_state_r   <= ST_IDLE;
            tx_mem_req_r <= 1'b0;
            tx_push_r    <= 1'b1;
            tx_data_r    <= tx_mem_rdata_i;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Receive engine: FIFO pop then RAM write
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_state_r   <= ST_IDLE;
      rx_mem_req_r <= 1'b0;
      rx_mem_r     <= '0;
      rx_pop_r     <= 1'b0;
    end else begin
      rx_pop_r <= 1'b0;
      unique case (rx_state_r)
        ST_IDLE: begin
          if (rx_start) begin
            rx_state_r     <= ST_WAIT;
            rx_pop_r       <= 1'b1;
            rx_mem_req_r   <= 1'b1;
            rx_mem_r.we    <= 1'b1;
            rx_mem_r.addr  <= rx_buf.beg + rx_cnt_r[rx_sel_r];
            rx_mem_r.wdata <= rx_byte_i.data;
          end
        end
        ST_WAIT: begin
          if (rx_rst_go || rx_mem_ack_i) begin
            rx_state_r   <= ST_IDLE;
            rx_mem_req_r <= 1'b0;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Receive error flags; a new error beats a same-cycle load clear
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_frm_r <= 2'b00;
      rx_par_r <= 2'b00;
      rx_ovf_r <= 2'b00;
    end else if (rx_rst_go) begin
      rx_frm_r <= 2'b00;
      rx_par_r <= 2'b00;
      rx_ovf_r <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (rx_start && rx_sel_r == i[0] && uart_mode_i && rx_byte_i.frame_err)
          rx_frm_r[i] <= 1'b1;
        else if (rx_set[i])
          rx_frm_r[i] <= 1'b0;
        if (rx_start && rx_sel_r == i[0] && uart_mode_i && rx_byte_i.parity_err)
          rx_par_r[i] <= 1'b1;
        else if (rx_set[i])
          rx_par_r[i] <= 1'b0;
        if (rx_start && rx_sel_r == i[0] && ovr_pend_r)
          rx_ovf_r[i] <= 1'b1;
        else if (rx_set[i])
          rx_ovf_r[i] <= 1'b0;
      end
    end
  end

  // Overrun seen while no receive buffer was loaded
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      ovr_pend_r <= 1'b0;
    else if (rx_rst_go)
      ovr_pend_r <= 1'b0;
    else if (rx_fifo_full_i && rx_load_r == 2'b00)
      ovr_pend_r <= 1'b1;
    else if (rx_start)
      ovr_pend_r <= 1'b0;
  end

  // ==========================================================
  // Saved-count status on frame-select deassertion
  logic fs_deassert;
  assign fs_deassert = spi_slave_i && !fsn_q_r && frame_select_n_i;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fsn_q_r     <= 1'b1;
      ssel_r      <= `SSEL_NONE;
      saved_cnt_r <= '0;
    end else begin
      fsn_q_r <= frame_select_n_i;
      if (rx_rst_go) begin
        ssel_r <= `SSEL_NONE;
      end else if (fs_deassert) begin
        // Only codes 2, 3, 6, 7 can arise
        ssel_r[0]               <= rx_sel_r;
        ssel_r[`SSEL_SAVED_BIT] <= 1'b1;
        ssel_r[`SSEL_MULTI_BIT] <= ssel_r != `SSEL_NONE;
        saved_cnt_r             <= rx_cnt_r[rx_sel_r];
      end else if (rx_set != 2'b00) begin
        ssel_r <= `SSEL_NONE;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign hrdata_o              = hrdata_r;
  assign hreadyout_o           = hreadyout_r;
  assign hresp_o               = hresp_r;
  assign tx_push_o             = tx_push_r;
  assign tx_data_o             = tx_data_r;
  assign rx_pop_o              = rx_pop_r;
  assign tx_mem_req_o          = tx_mem_req_r;
  assign tx_mem_o              = tx_mem_r;
  assign rx_mem_req_o          = rx_mem_req_r;
  assign rx_mem_o              = rx_mem_r;
  assign saved_receive_count_o = saved_cnt_r;

endmodule

// [hdl/serial_dma_cfg.svh]
// Purpose: Constants for the serial DMA control and status block
// Assumes: Byte addresses on a 32-bit AHB-Lite bus
// Notes:   Offsets, field positions and encodings as `define macros
`ifndef SERIAL_DMA_CFG_SVH
`define SERIAL_DMA_CFG_SVH

// ==========================================================
// Register map
`define STATUS_ADDR     32'h4000c82c
`define CONTROL_ADDR    32'h4000c830
`define HTRANS_BUSY_BIT 1

// ==========================================================
// Control fields
`define CTL_TX_RST      5
`define CTL_RX_RST      4
`define CTL_TX_LOAD_MSB 3
`define CTL_TX_LOAD_LSB 2
`define CTL_RX_LOAD_MSB 1
`define CTL_RX_LOAD_LSB 0

// ==========================================================
// Saved-count status encodings
`define SSEL_NONE       3'h0
`define SSEL_SAVED_BIT  1
`define SSEL_MULTI_BIT  2

// ==========================================================
// Reset values
`define HRDATA_RESET    32'h0000_0000

`endif

// [hdl/serial_dma_pkg.sv]
// Purpose: Types for the serial DMA control and status block
// Assumes: 14-bit RAM byte addresses
// Notes:   Constants live in serial_dma_cfg.svh
package serial_dma_pkg;

  typedef logic [13:0] addr_t;

  // Begin and inclusive end address of one buffer
  typedef struct packed {
    addr_t beg;
    addr_t fin;
  } buf_addr_t;

  // One byte from the receive FIFO with its error marks
  typedef struct packed {
    logic       frame_err;
    logic       parity_err;
    logic [7:0] data;
  } rx_byte_t;

  // One RAM access
  typedef struct packed {
    logic       we;
    addr_t      addr;
    logic [7:0] wdata;
  } mem_req_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } chan_state_t;

endpackage

// [test/serial_dma_checker.sv]
// Purpose: Port checks for the serial DMA control/status block
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound to every instance of the block
`timescale 1ns/1ns
`include "serial_dma_cfg.svh"

module serial_dma_checker
  import serial_dma_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  input  wire logic        hreadyout_o,
  input  wire logic        hresp_o,
  input  wire logic        tx_space_i,
  input  wire logic        tx_push_o,
  input  wire logic [7:0]  tx_data_o,
  input  wire logic        rx_avail_i,
  input  wire logic        rx_pop_o,
  input  wire logic        tx_mem_req_o,
  input  wire mem_req_t    tx_mem_o,
  input  wire logic        tx_mem_ack_i,
  input  wire logic [7:0]  tx_mem_rdata_i,
  input  wire logic        rx_mem_req_o,
  input  wire mem_req_t    rx_mem_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // ======================
  // Control writes
  sequence s_ctl_addr;
    hsel_i && htrans_i[1] && hready_i && hwrite_i && haddr_i == `CONTROL_ADDR;
  endsequence
  sequence s_tx_rst;
    s_ctl_addr ##1 (hready_i && hwdata_i[`CTL_TX_RST]);
  endsequence
  sequence s_rx_rst;
    s_ctl_addr ##1 (hready_i && hwdata_i[`CTL_RX_RST]);
  endsequence

  // Control write in its data phase; a channel reset there abandons a read
  logic ctl_dph_r;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      ctl_dph_r <= 1'b0;
    else if (hready_i)
      ctl_dph_r <= hsel_i && htrans_i[1] && hwrite_i && haddr_i == `CONTROL_ADDR;
  end

  // ======================
  // Checks
  AST_OKAY: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not ready or not okay");
  AST_TX_RST: assert property (s_tx_rst |=> !tx_mem_req_o [*2])
    else $error("transmit request after channel reset");
  AST_RX_RST: assert property (s_rx_rst |=> (!rx_pop_o && !rx_mem_req_o) [*2])
    else $error("receive activity after channel reset");
  AST_PUSH_DATA: assert property (tx_mem_req_o && tx_mem_ack_i &&
    !(ctl_dph_r && hwdata_i[`CTL_TX_RST]) |=>
    tx_push_o && !tx_mem_req_o && tx_data_o == $past(tx_mem_rdata_i))
    else $error("push does not follow memory answer");
  AST_PUSH_ONCE: assert property (tx_push_o |=> !tx_push_o && !tx_mem_req_o)
    else $error("push longer than one cycle or request too soon");
  AST_TX_SPACE: assert property ($rose(tx_mem_req_o) |-> $past(tx_space_i))
    else $error("transmit read started without fifo space");
  AST_TX_READ: assert property (tx_mem_req_o |-> !tx_mem_o.we)
    else $error("transmit channel writes memory");
  AST_POP_ONCE: assert property (rx_pop_o |-> rx_mem_req_o && rx_mem_o.we ##1 !rx_pop_o)
    else $error("pop without memory write or too long");
  AST_RX_AVAIL: assert property ($rose(rx_pop_o) |-> $past(rx_avail_i))
    else $error("pop from empty receive fifo");
endmodule

bind serial_dma_ctrl_status serial_dma_checker chk (.ref_clk_i, .rst_n_i, .hsel_i,
  .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i, .hreadyout_o, .hresp_o,
  .tx_space_i, .tx_push_o, .tx_data_o, .rx_avail_i, .rx_pop_o, .tx_mem_req_o,
  .tx_mem_o, .tx_mem_ack_i, .tx_mem_rdata_i, .rx_mem_req_o, .rx_mem_o);

// [test/far_side_model.sv]
// Purpose: RAM and receive FIFO head seen by the DMA channels
// Assumes: One access outstanding per channel
// Notes:   Answer latency set by lat_i, 0 is prompt
`timescale 1ns/1ns

module far_side_model
  import serial_dma_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [1:0] lat_i,
  input  wire logic [1:0] err_i,
  input  wire logic       tx_req_i,
  input  wire mem_req_t   tx_mem_i,
  output logic            tx_ack_o,
  output logic      [7:0] tx_rdata_o,
  input  wire logic       rx_req_i,
  output logic            rx_ack_o,
  input  wire logic       rx_pop_i,
  output rx_byte_t        rx_byte_o,
  output logic      [7:0] wr_cnt_o
);
  logic [1:0] tw_r;
  logic [1:0] rw_r;
  logic [7:0] seq_r;

  // ======================
  // RAM pattern, inverted outside the answer cycle
  assign tx_rdata_o = (tx_mem_i.addr[7:0] ^ 8'h5a) ^ {8{~tx_ack_o}};
  assign rx_byte_o  = {err_i, seq_r};

  // Delayed one-cycle answers, byte sequence, write count
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tw_r     <= 2'h0;
      rw_r     <= 2'h0;
      tx_ack_o <= 1'b0;
      rx_ack_o <= 1'b0;
      seq_r    <= 8'h00;
      wr_cnt_o <= 8'h00;
    end else begin
      tx_ack_o <= tx_req_i && !tx_ack_o && tw_r == lat_i;
      tw_r     <= (tx_req_i && !tx_ack_o && tw_r != lat_i) ? tw_r + 2'h1 : 2'h0;
      rx_ack_o <= rx_req_i && !rx_ack_o && rw_r == lat_i;
      rw_r     <= (rx_req_i && !rx_ack_o && rw_r != lat_i) ? rw_r + 2'h1 : 2'h0;
      seq_r    <= seq_r + {7'h00, rx_pop_i};
      wr_cnt_o <= wr_cnt_o + {7'h00, rx_ack_o};
    end
  end
endmodule

// [test/tb_serial_dma_ctrl_status.sv]
// Purpose: Self-checking bench for serial DMA control/status
// Assumes: Zero-wait AHB-Lite slave, far side from far_side_model
// Notes:   Expected values queued by driver, compared by watcher
`timescale 1ns/1ns
`include "serial_dma_cfg.svh"

`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end

module tb_serial_dma_ctrl_status
  import serial_dma_pkg::*;
;
  localparam logic [31:0] CTRL = `CONTROL_ADDR;
  localparam logic [31:0] STAT = `STATUS_ADDR;
  logic        ref_clk_i, rst_n_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
  logic        uart_mode_i, spi_slave_i, frame_select_n_i, tx_space_i, tx_push_o;
  logic        rx_avail_i, rx_fifo_full_i, rx_pop_o, tx_mem_req_o, tx_mem_ack_i;
  logic        rx_mem_req_o, rx_mem_ack_i, rd_dph;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, ev;
  logic [1:0]  htrans_i, lat, err;
  logic [7:0]  tx_data_o, tx_mem_rdata_i, wcnt;
  logic [13:0] ba;
  buf_addr_t   tx_buf_a_i, tx_buf_b_i, rx_buf_a_i, rx_buf_b_i;
  rx_byte_t    rx_byte_i;
  mem_req_t    tx_mem_o, rx_mem_o;
  addr_t       saved_receive_count_o;
  int          checked, err_total, cyc;
  logic [31:0] rd_q[$], tx_q[$], rx_q[$];

  serial_dma_ctrl_status DUT (.ref_clk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i,
    .hwrite_i, .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o,
    .hreadyout_o, .hresp_o, .uart_mode_i, .spi_slave_i, .frame_select_n_i,
    .tx_buf_a_i, .tx_buf_b_i, .rx_buf_a_i, .rx_buf_b_i, .tx_space_i, .tx_push_o,
    .tx_data_o, .rx_avail_i, .rx_byte_i, .rx_fifo_full_i, .rx_pop_o, .tx_mem_req_o,
    .tx_mem_o, .tx_mem_ack_i, .tx_mem_rdata_i, .rx_mem_req_o, .rx_mem_o,
    .rx_mem_ack_i, .saved_receive_count_o);

  far_side_model far (.clk_i(ref_clk_i), .rst_n_i(rst_n_i), .lat_i(lat), .err_i(err),
    .tx_req_i(tx_mem_req_o), .tx_mem_i(tx_mem_o), .tx_ack_o(tx_mem_ack_i),
    .tx_rdata_o(tx_mem_rdata_i), .rx_req_i(rx_mem_req_o), .rx_ack_o(rx_mem_ack_i),
    .rx_pop_i(rx_pop_o), .rx_byte_o(rx_byte_i), .wr_cnt_o(wcnt));

  // ======================
  // Clock, verdict
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ======================
  // Watcher: compares results against oldest note
  always @(posedge ref_clk_i) begin
    if (rd_dph && hreadyout_o) begin
      ev = rd_q.pop_front();
      `CHK("read data", ev, hrdata_o)
    end
    if (tx_push_o) begin
      `CHK("tx byte expected", 1'b1, tx_q.size() != 0)
      ev = tx_q.pop_front();
      `CHK("tx byte", ev[7:0], tx_data_o)
    end
    if (rx_mem_req_o && rx_mem_ack_i) begin
      ev = rx_q.pop_front();
      `CHK("rx write", ev[21:0], {rx_mem_o.addr, rx_mem_o.wdata})
    end
    rd_dph <= hsel_i && htrans_i[1] && hreadyout_o && !hwrite_i;
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  // ======================
  // AHB-Lite single transfers
  task automatic bus(input logic w, input logic [31:0] a, d);
    hsel_i   <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    haddr_i  <= a;
    @(posedge ref_clk_i);
    while (!hreadyout_o) @(posedge ref_clk_i);
    hsel_i   <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    @(posedge ref_clk_i);
    while (!hreadyout_o) @(posedge ref_clk_i);
  endtask

  task automatic rd(input logic [31:0] a, e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic fs_pulse();
    frame_select_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    frame_select_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
  endtask

  // ======================
  // Main sequence
  initial begin
    void'($urandom(32'h05da));
    ba = 14'($urandom % 64);
    {rst_n_i, hsel_i, hwrite_i, uart_mode_i, spi_slave_i, tx_space_i} = '0;
    {rx_avail_i, rx_fifo_full_i, rd_dph, htrans_i, err, lat} = '0;
    {haddr_i, hwdata_i, checked, err_total, cyc} = '0;
    frame_select_n_i = 1'b1;
    tx_buf_a_i = {ba, ba + 14'h2};
    tx_buf_b_i = {14'h20, 14'h21};
    rx_buf_a_i = {14'h100, 14'h101};
    rx_buf_b_i = {14'h108, 14'h108};
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    // Reset values, unmapped place
    rd(STAT, 32'h0);
    rd(CTRL, 32'h0);
    bus(1'b1, 32'h4000c834, 32'h3f);
    rd(32'h4000c834, 32'h0);
    rd(CTRL, 32'h0);
    // Both transmit buffers in one write, zero write ignored
    bus(1'b1, CTRL, 32'hc);
    rd(CTRL, 32'hc);
    rd(STAT, 32'h4);
    bus(1'b1, CTRL, 32'h0);
    rd(CTRL, 32'hc);
    for (int i = 0; i < 3; i++) tx_q.push_back((ba[7:0] + 8'(i)) ^ 8'h5a);
    for (int i = 0; i < 2; i++) tx_q.push_back((8'h20 + 8'(i)) ^ 8'h5a);
    tx_space_i <= 1'b1;
    lat        <= 2'h2;
    while (tx_q.size() != 0) @(posedge ref_clk_i);
    repeat (4) @(posedge ref_clk_i);
    rd(CTRL, 32'h0);
    rd(STAT, 32'h0);
    // Transmit reset while a memory read waits for its answer
    bus(1'b1, CTRL, 32'h4);
    rd(STAT, 32'h4);
    bus(1'b1, CTRL, 32'h20);
    rd(CTRL, 32'h0);
    rd(STAT, 32'h0);
    // Overrun while unloaded, frame errors into A
    uart_mode_i    <= 1'b1;
    err            <= 2'b10;
    lat            <= 2'h0;
    rx_fifo_full_i <= 1'b1;
    @(posedge ref_clk_i);
    rx_fifo_full_i <= 1'b0;
    rx_avail_i     <= 1'b1;
    rx_q.push_back({14'h100, 8'h00});
    rx_q.push_back({14'h101, 8'h01});
    bus(1'b1, CTRL, 32'h1);
    while (wcnt != 8'h2) @(posedge ref_clk_i);
    repeat (4) @(posedge ref_clk_i);
    rd(STAT, 32'h110);
    // Parity error into B
    err <= 2'b01;
    rx_q.push_back({14'h108, 8'h02});
    bus(1'b1, CTRL, 32'h2);
    while (wcnt != 8'h3) @(posedge ref_clk_i);
    repeat (4) @(posedge ref_clk_i);
    rd(STAT, 32'h190);
    // Deassertion ignored outside SPI slave mode, then saved with A's count
    fs_pulse();
    rd(STAT, 32'h190);
    spi_slave_i <= 1'b1;
    fs_pulse();
    rd(STAT, 32'h990);
    `CHK("saved count", 14'h2, saved_receive_count_o)
    // Reload A clears its flags and the saved-count status, B's flag stays
    rx_avail_i <= 1'b0;
    bus(1'b1, CTRL, 32'h1);
    rd(CTRL, 32'h1);
    rd(STAT, 32'h81);
    // Frame-select deassertions in SPI slave mode
    spi_slave_i <= 1'b1;
    fs_pulse();
    rd(STAT, 32'h881);
    fs_pulse();
    rd(STAT, 32'h1881);
    `CHK("saved count", 14'h0, saved_receive_count_o)
    // Receive reset clears load bits, error flags and saved-count status
    bus(1'b1, CTRL, 32'h10);
    rd(CTRL, 32'h0);
    rd(STAT, 32'h0);
    repeat (2) @(posedge ref_clk_i);
    `CHK("notes left", 32'h0, 32'(rd_q.size() + tx_q.size() + rx_q.size()))
    report_and_stop();
  end
endmodule
